/* File: rtl/sep_pkg.sv */
// shared constants for the serial nonvolatile memory device and its host controller
// assumes both ends share one system clock of 250 MHz
package sep_pkg;
   // system clock and link timing
   localparam int CLK_NS       = 4;
   localparam int SCK_HALF_NS  = 25;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int BYTE_BITS    = 8;
   localparam int ADDR_W       = 16;

   // command opcodes
   localparam logic [7:0] OP_NONE            = 8'h00;
   localparam logic [7:0] OP_STATUS_WRITE    = 8'h01;
   localparam logic [7:0] OP_READ            = 8'h03;
   localparam logic [7:0] OP_CLEAR_LATCH     = 8'h04;
   localparam logic [7:0] OP_STATUS_READ     = 8'h05;
   localparam logic [7:0] OP_SET_LATCH       = 8'h06;
   localparam logic [7:0] OP_FAST_READ       = 8'h0B;
   localparam logic [7:0] OP_DEEP_SLEEP      = 8'h79;
   localparam logic [7:0] OP_WAKE            = 8'hAB;
   localparam logic [7:0] OP_SLEEP           = 8'hB9;

   // status register bit positions
   localparam int SR_BUSY   = 0;
   localparam int SR_LATCH  = 1;
   localparam int SR_BP_LO  = 2;
   localparam int SR_BP_HI  = 3;
   localparam int SR_LPIDLE = 5;
   localparam int SR_AUTO   = 6;
   localparam int SR_PROT   = 7;

   // frame byte indexes
   localparam logic [2:0] IDX_OP      = 3'h0;
   localparam logic [2:0] IDX_ADDR_HI = 3'h1;
   localparam logic [2:0] IDX_ADDR_LO = 3'h2;
   localparam logic [2:0] IDX_DUMMY   = 3'h3;
   localparam logic [2:0] IDX_MAX     = 3'h7;

   // block protect encodings
   localparam logic [1:0] BP_NONE    = 2'h0;
   localparam logic [1:0] BP_QUARTER = 2'h1;
   localparam logic [1:0] BP_HALF    = 2'h2;

   // host register offsets
   localparam logic [3:0] REG_CMD  = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // device power states
   typedef enum logic [5:0] {
      PS_ACTIVE   = 6'b000001,
      PS_STANDBY  = 6'b000010,
      PS_LOW_IDLE = 6'b000100,
      PS_AUTO     = 6'b001000,
      PS_SLEEP    = 6'b010000,
      PS_DEEP     = 6'b100000
   } sep_power_t;

   // host link states
   typedef enum logic [4:0] {
      HS_IDLE  = 5'b00001,
      HS_LOW   = 5'b00010,
      HS_HIGH  = 5'b00100,
      HS_HOLD  = 5'b01000,
      HS_GAP   = 5'b10000
   } sep_hstate_t;
endpackage : sep_pkg

/* File: rtl/sep_spi_if.sv */
// serial link between the memory device and the host controller
// assumes the bench or a top ties the two modports; serial_out reads low when not driven
`timescale 1ns/1ps
interface sep_spi_if;
   logic cs_n;
   logic sck;
   logic serial_in;
   logic wp_n;
   logic serial_out;
   logic serial_out_oe;
   logic so_line;

   // undriven line settles low, no high impedance modelled
   assign so_line = serial_out_oe & serial_out;

   modport dev  (input cs_n, sck, serial_in, wp_n, output serial_out, serial_out_oe);
   modport host (output cs_n, sck, serial_in, wp_n, input so_line);
endinterface : sep_spi_if

/* File: rtl/sep_device.sv */
// serial nonvolatile memory device: command decoder, power modes, status register, reads
// assumes link pins arrive asynchronously and the link clock is far slower than aclk
//
// Overview of operation
// R01: idle with chip select high means standby
// R02: after sleep only wake command is accepted
// R03: deep sleep ignores all commands, exit pulse only
// R04: auto bit makes idle device sleep, select wakes
// R05: low-power bit selects low-power idle state
// R06: host enables low-power bits only at slow clock
// R07: sleep command overrides automatic modes, select ignored
// R08: latch zero at reset, writes need latch
// R09: latch cleared by disable and sleep commands
// R10: partial byte frame executes nothing, latch kept
// R11: disable command ignores write-protect pin
// R12: status read shifts out whole status byte
// R13: status write updates only five nonvolatile bits
// R14: protect bit cannot clear while pin low
// R15: read takes opcode then two address bytes
// R16: after read header, serial input ignored
// R17: read increments address and wraps to zero
// R18: fast read adds one dummy byte
// R19: fast read increments and wraps too
// R20: status layout protect, auto, lowpower, 0, bp, latch, busy
// R21: status locked only with bit set, pin low
// R22: block protect none, quarter, half, all
// R23: sample on rising, change on falling, MSB first
`timescale 1ns/1ps
module sep_device #(
   parameter int         ADDR_W   = sep_pkg::ADDR_W,
   parameter logic [4:0] NV_RESET = 5'h00
) (
   // system
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // link
   sep_spi_if.dev                 spi,
   // user side
   input  wire logic              array_busy,
   input  wire logic              deep_exit,
   input  wire logic              mem_wr_en,
   input  wire logic [ADDR_W-1:0] mem_wr_addr,
   input  wire logic [7:0]        mem_wr_data,
   output logic                   mem_wr_refused,
   output logic [7:0]             status,
   output sep_pkg::sep_power_t    power_state
);
   logic [7:0]        mem [0:(2**ADDR_W)-1];
   logic [2:0]        cs_s, sck_s;
   logic [1:0]        si_s, wp_s;
   logic [2:0]        bit_q, byte_q;
   logic [7:0]        rx_q, op_q, tx_q, wr_val_q;
   logic [ADDR_W-1:0] addr_q;
   logic              so_q, oe_q, latch_q, prot_q, auto_q, lpidle_q;
   logic [1:0]        bp_q;
   sep_pkg::sep_power_t state_q;
   logic              cs_low, cs_fall, cs_rise, sck_rise, sck_fall, byte_done, whole_bytes;
   logic [7:0]        rx_byte, rd_byte;
   logic              accept, first_data, next_data, sr_locked;
   logic [ADDR_W-1:0] rd_addr;

   // two-stage synchronisers, third stage only for edge finding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cs_s  <= 3'h7;
         sck_s <= 3'h0;
         si_s  <= 2'h0;
         wp_s  <= 2'h3;
      end else begin
         cs_s  <= {cs_s[1:0], spi.cs_n};
         sck_s <= {sck_s[1:0], spi.sck};
         si_s  <= {si_s[0], spi.serial_in};
         wp_s  <= {wp_s[0], spi.wp_n};
      end
   end

   assign cs_low   = ~cs_s[1];
   assign cs_fall  = ~cs_s[1] & cs_s[2];
   assign cs_rise  = cs_s[1] & ~cs_s[2];
   // R23 rising samples
   assign sck_rise = cs_low & sck_s[1] & ~sck_s[2];
   assign sck_fall = cs_low & ~sck_s[1] & sck_s[2];
   assign rx_byte  = {rx_q[6:0], si_s[1]};
   assign byte_done = sck_rise && (bit_q == 3'(sep_pkg::BYTE_BITS - 1));
   // R10 whole bytes only
   assign whole_bytes = (bit_q == 3'h0);
   // R21 lock condition
   assign sr_locked = prot_q & ~wp_s[1];

   // R20 status layout
   assign status = {prot_q, auto_q, lpidle_q, 1'b0, bp_q, latch_q, array_busy};

   // opcode gate: deep sleep takes nothing, sleep only wake, busy only status read
   always_comb begin
      // R03 deep ignores all
      if (state_q == sep_pkg::PS_DEEP)
         accept = 1'b0;
      // R02 R07 only wake
      else if (state_q == sep_pkg::PS_SLEEP)
         accept = (rx_byte == sep_pkg::OP_WAKE);
      else if (array_busy)
         accept = (rx_byte == sep_pkg::OP_STATUS_READ);
      else
         accept = 1'b1;
   end

   // R15 R18 read address phases
   assign first_data = ((op_q == sep_pkg::OP_READ) && (byte_q == sep_pkg::IDX_ADDR_LO)) ||
                       ((op_q == sep_pkg::OP_FAST_READ) && (byte_q == sep_pkg::IDX_DUMMY));
   assign next_data  = ((op_q == sep_pkg::OP_READ) && (byte_q > sep_pkg::IDX_ADDR_LO)) ||
                       ((op_q == sep_pkg::OP_FAST_READ) && (byte_q > sep_pkg::IDX_DUMMY));
   // R17 R19 natural wrap to zero
   assign rd_addr = (op_q == sep_pkg::OP_READ && byte_q == sep_pkg::IDX_ADDR_LO) ?
                    {addr_q[ADDR_W-1:8], rx_byte} :
                    (first_data ? addr_q : addr_q + ADDR_W'(1));
   assign rd_byte = mem[rd_addr];

   // frame bit and byte counters, cleared at every select edge
   always_ff @(posedge aclk) begin
      if (!aresetn || cs_fall || cs_rise) begin
         bit_q  <= 3'h0;
         byte_q <= 3'h0;
         rx_q   <= 8'h00;
      end else if (sck_rise) begin
         bit_q <= bit_q + 3'h1;
         rx_q  <= rx_byte;
         if (byte_done && byte_q != sep_pkg::IDX_MAX)
            byte_q <= byte_q + 3'h1;
      end
   end

   // opcode, address and status-write value capture
   always_ff @(posedge aclk) begin
      if (!aresetn || cs_fall) begin
         op_q     <= sep_pkg::OP_NONE;
         addr_q   <= '0;
         wr_val_q <= 8'h00;
      end else if (byte_done) begin
         if (byte_q == sep_pkg::IDX_OP)
            op_q <= accept ? rx_byte : sep_pkg::OP_NONE;
         // R16 later input ignored
         else if (byte_q == sep_pkg::IDX_ADDR_HI) begin
            addr_q[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0];
            wr_val_q           <= rx_byte;
         end else if (op_q == sep_pkg::OP_READ && byte_q == sep_pkg::IDX_ADDR_LO)
            addr_q[7:0] <= rx_byte;
         else if (op_q == sep_pkg::OP_FAST_READ && byte_q == sep_pkg::IDX_ADDR_LO)
            addr_q[7:0] <= rx_byte;
         // R17 R19 step after each byte
         else if (next_data)
            addr_q <= addr_q + ADDR_W'(1);
      end
   end

   // output shifter: loads at a byte boundary, shifts on falling edges
   always_ff @(posedge aclk) begin
      if (!aresetn || cs_fall || cs_rise) begin
         tx_q <= 8'h00;
         so_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (byte_done) begin
         // R12 status repeats each byte
         if ((byte_q == sep_pkg::IDX_OP && accept && rx_byte == sep_pkg::OP_STATUS_READ) ||
             (byte_q != sep_pkg::IDX_OP && op_q == sep_pkg::OP_STATUS_READ)) begin
            tx_q <= status;
            oe_q <= 1'b1;
         end else if (first_data || next_data) begin
            tx_q <= rd_byte;
            oe_q <= 1'b1;
         end
      // R23 MSB first on falling
      end else if (sck_fall && oe_q) begin
         so_q <= tx_q[7];
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end
   assign spi.serial_out    = so_q;
   assign spi.serial_out_oe = oe_q & cs_low;

   // write latch; latch changes only at select rise after exactly one whole byte
   always_ff @(posedge aclk) begin
      // R08 latch zero after reset
      if (!aresetn)
         latch_q <= 1'b0;
      else if (cs_rise && whole_bytes && byte_q == 3'h1) begin
         if (op_q == sep_pkg::OP_SET_LATCH)
            latch_q <= 1'b1;
         // R09 R11 disable and sleep clear
         else if (op_q == sep_pkg::OP_CLEAR_LATCH || op_q == sep_pkg::OP_SLEEP)
            latch_q <= 1'b0;
      end
   end

   // nonvolatile status bits, reset value stands in for stored contents
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {prot_q, auto_q, lpidle_q, bp_q} <= NV_RESET;
      // R08 R13 R14 R21 gated update
      end else if (cs_rise && whole_bytes && byte_q == 3'h2 && op_q == sep_pkg::OP_STATUS_WRITE &&
                   latch_q && !sr_locked) begin
         prot_q   <= wr_val_q[sep_pkg::SR_PROT];
         auto_q   <= wr_val_q[sep_pkg::SR_AUTO];
         lpidle_q <= wr_val_q[sep_pkg::SR_LPIDLE];
         bp_q     <= {wr_val_q[sep_pkg::SR_BP_HI], wr_val_q[sep_pkg::SR_BP_LO]};
      end
   end

   // power state; explicit sleep commands outrank the automatic idle modes
   always_ff @(posedge aclk) begin
      if (!aresetn)
         state_q <= sep_pkg::PS_STANDBY;
      else if (cs_rise && whole_bytes && byte_q == 3'h1 && op_q == sep_pkg::OP_SLEEP)
         state_q <= sep_pkg::PS_SLEEP;
      else if (cs_rise && whole_bytes && byte_q == 3'h1 && op_q == sep_pkg::OP_DEEP_SLEEP)
         state_q <= sep_pkg::PS_DEEP;
      else begin
         unique case (state_q)
            // R03 exit only by pulse
            sep_pkg::PS_DEEP:
               if (deep_exit)
                  state_q <= sep_pkg::PS_STANDBY;
            // R02 R07 wake at 8th rise
            sep_pkg::PS_SLEEP:
               if (byte_done && byte_q == sep_pkg::IDX_OP && accept)
                  state_q <= sep_pkg::PS_ACTIVE;
            sep_pkg::PS_ACTIVE, sep_pkg::PS_STANDBY, sep_pkg::PS_LOW_IDLE, sep_pkg::PS_AUTO:
               // R04 R05 select wakes
               if (cs_low || array_busy)
                  state_q <= sep_pkg::PS_ACTIVE;
               else if (auto_q)
                  state_q <= sep_pkg::PS_AUTO;
               else if (lpidle_q)
                  state_q <= sep_pkg::PS_LOW_IDLE;
               // R01 plain standby
               else
                  state_q <= sep_pkg::PS_STANDBY;
            default:
               state_q <= sep_pkg::PS_STANDBY;
         endcase
      end
   end
   assign power_state = state_q;

   // R22 region decode, stands in for array writes from the user side
   always_comb begin
      unique case (bp_q)
         sep_pkg::BP_NONE:    mem_wr_refused = 1'b0;
         sep_pkg::BP_QUARTER: mem_wr_refused = &mem_wr_addr[ADDR_W-1:ADDR_W-2];
         sep_pkg::BP_HALF:    mem_wr_refused = mem_wr_addr[ADDR_W-1];
         default:             mem_wr_refused = 1'b1;
      endcase
      mem_wr_refused = mem_wr_refused & mem_wr_en;
   end

   // array contents; no reset, preloaded over the user port
   always_ff @(posedge aclk) begin
      if (mem_wr_en && !mem_wr_refused)
         mem[mem_wr_addr] <= mem_wr_data;
   end
endmodule : sep_device

/* File: rtl/sep_host.sv */
// host controller: AXI4-Lite register slave that runs one serial frame per command
// assumes the device samples on rising and shifts on falling link clock edges
`timescale 1ns/1ps
module sep_host #(
   parameter int HALF_CYC = sep_pkg::SCK_HALF_CYC
) (
   // system
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // link
   sep_spi_if.host          spi,
   // axi4-lite write
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   logic [3:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        aw_got_q, w_got_q, start;
   logic [7:0]  op_q, wval_q, len_q, rx_last_q, rx_cnt_q, tx_q, rx_q;
   logic [15:0] addr_q;
   logic        wp_q, sck_q, cs_n_q;
   logic [1:0]  so_s;
   logic [2:0]  bit_q;
   logic [7:0]  byte_q;
   logic [15:0] tmr_q;
   sep_pkg::sep_hstate_t st_q;
   logic        tmr_done;
   logic [7:0]  next_tx;

   // write channels taken in either order; one response after both
   assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_got_q & ~s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q     <= 1'b0;
         w_got_q      <= 1'b0;
         awaddr_q     <= 4'h0;
         wdata_q      <= 32'h0;
         wstrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= sep_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb; // master may drop strobes once taken
         end
         if (aw_got_q && w_got_q) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == sep_pkg::REG_CMD || awaddr_q == sep_pkg::REG_ADDR) ?
                            sep_pkg::RESP_OKAY : sep_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // a command write while a frame runs is dropped
   assign start = aw_got_q && w_got_q && awaddr_q == sep_pkg::REG_CMD && st_q == sep_pkg::HS_IDLE;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op_q   <= 8'h00;
         wval_q <= 8'h00;
         len_q  <= 8'h00;
         addr_q <= 16'h0;
         wp_q   <= 1'b1;
      end else if (aw_got_q && w_got_q) begin
         if (start)
            {len_q, wval_q, op_q} <= wdata_q[23:0];
         if (awaddr_q == sep_pkg::REG_ADDR && wstrb_q[0])
            addr_q[7:0] <= wdata_q[7:0];
         if (awaddr_q == sep_pkg::REG_ADDR && wstrb_q[1])
            addr_q[15:8] <= wdata_q[15:8];
         if (awaddr_q == sep_pkg::REG_ADDR && wstrb_q[2])
            wp_q <= wdata_q[16];
      end
   end

   // read channel, one cycle after the address
   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= sep_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= sep_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            sep_pkg::REG_CMD:  s_axi_rdata <= {8'h00, len_q, wval_q, op_q};
            sep_pkg::REG_ADDR: s_axi_rdata <= {15'h0, wp_q, addr_q};
            sep_pkg::REG_STAT: s_axi_rdata <= {8'h00, rx_cnt_q, rx_last_q, 7'h0, st_q != sep_pkg::HS_IDLE};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= sep_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // returned data passes two flip-flops before use
   always_ff @(posedge aclk) begin
      if (!aresetn)
         so_s <= 2'h0;
      else
         so_s <= {so_s[0], spi.so_line};
   end

   // frame bytes: opcode, address high, address low, write value, then zeros
   // R15 R18 address bytes, dummy
   always_comb begin
      unique case (byte_q + 8'h1)
         8'h1:    next_tx = addr_q[15:8];
         8'h2:    next_tx = addr_q[7:0];
         8'h3:    next_tx = wval_q;
         default: next_tx = 8'h00;
      endcase
   end
   assign tmr_done = (tmr_q == 16'h0);

   // R23 mode 0 framer; sampling late in the high phase covers the device's sync delay
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q      <= sep_pkg::HS_IDLE;
         cs_n_q    <= 1'b1;
         sck_q     <= 1'b0;
         tx_q      <= 8'h00;
         rx_q      <= 8'h00;
         bit_q     <= 3'h0;
         byte_q    <= 8'h00;
         tmr_q     <= 16'h0;
         rx_last_q <= 8'h00;
         rx_cnt_q  <= 8'h00;
      end else begin
         if (!tmr_done)
            tmr_q <= tmr_q - 16'h1;
         unique case (st_q)
            sep_pkg::HS_IDLE:
               if (start && wdata_q[23:16] != 8'h00) begin
                  st_q     <= sep_pkg::HS_LOW;
                  cs_n_q   <= 1'b0;
                  tx_q     <= wdata_q[7:0];
                  bit_q    <= 3'h0;
                  byte_q   <= 8'h00;
                  rx_cnt_q <= 8'h00;
                  tmr_q    <= 16'(HALF_CYC - 1);
               end
            sep_pkg::HS_LOW:
               if (tmr_done) begin
                  st_q  <= sep_pkg::HS_HIGH;
                  sck_q <= 1'b1;
                  tmr_q <= 16'(HALF_CYC - 1);
               end
            sep_pkg::HS_HIGH:
               if (tmr_done) begin
                  sck_q <= 1'b0;
                  rx_q  <= {rx_q[6:0], so_s[1]};
                  tmr_q <= 16'(HALF_CYC - 1);
                  bit_q <= bit_q + 3'h1;
                  tx_q  <= {tx_q[6:0], 1'b0};
                  st_q  <= sep_pkg::HS_LOW;
                  if (bit_q == 3'(sep_pkg::BYTE_BITS - 1)) begin
                     rx_last_q <= {rx_q[6:0], so_s[1]};
                     rx_cnt_q  <= rx_cnt_q + 8'h1;
                     byte_q    <= byte_q + 8'h1;
                     tx_q      <= next_tx;
                     if (byte_q + 8'h1 == len_q)
                        st_q <= sep_pkg::HS_HOLD;
                  end
               end
            sep_pkg::HS_HOLD:
               if (tmr_done) begin
                  st_q   <= sep_pkg::HS_GAP;
                  cs_n_q <= 1'b1;
                  tmr_q  <= 16'(HALF_CYC - 1);
               end
            sep_pkg::HS_GAP:
               if (tmr_done)
                  st_q <= sep_pkg::HS_IDLE;
            default:
               st_q <= sep_pkg::HS_IDLE;
         endcase
      end
   end

   assign spi.cs_n      = cs_n_q;
   assign spi.sck       = sck_q;
   assign spi.serial_in = tx_q[7];
   // R06 R14 pin level set by software
   assign spi.wp_n      = wp_q;
endmodule : sep_host

/* File: bench/sep_chk.sv */
// link checker: watches the serial link between host controller and device
// assumes one aclk domain and the host's default half period of 7 aclk
`timescale 1ns/1ps
module sep_chk (
   // system
   input wire logic aclk,
   input wire logic aresetn,
   // link
   input wire logic cs_n,
   input wire logic sck,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe
);
   logic       sck_q;
   logic [7:0] bits_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // delayed link clock to find its rising edges
   always_ff @(posedge aclk) begin
      sck_q <= sck;
   end
   // link clock rises per frame, cleared while deselected
   always_ff @(posedge aclk) begin
      if (cs_n) bits_q <= 8'h00;
      else if (sck & !sck_q) bits_q <= bits_q + 8'h01;
   end
   idle_clk_a: assert property (cs_n |-> !sck) else $error("link clock high while deselected");
   sck_high_a: assert property ($rose(sck) |-> sck[*5]) else $error("link clock high phase short");
   sck_low_a: assert property ($fell(sck) |-> (!sck)[*5]) else $error("link clock low phase short");
   sin_hold_a: assert property (sck && sck_q |-> $stable(serial_in)) else $error("input moved in high phase");
   so_edge_a: assert property (serial_out_oe && $changed(serial_out) |-> !sck) else $error("output moved in high phase");
   oe_idle_a: assert property (cs_n[*4] |-> !serial_out_oe) else $error("output driven while idle");
   oe_late_a: assert property ($rose(serial_out_oe) |-> bits_q >= 8'h08) else $error("output before header");
   frame_whole_a: assert property ($rose(cs_n) |-> bits_q[2:0] == 3'h0) else $error("frame ends mid byte");
endmodule : sep_chk

/* File: bench/tb.sv */
// bench: host controller and device joined by the link, driven over AXI4-Lite
// assumes the host hand-over timing; array contents seeded through the backdoor
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
   logic aclk = 1'b0, aresetn = 1'b0, array_busy = 1'b0, deep_exit = 1'b0, mem_wr_en = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mem_wr_refused;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [1:0]  s_axi_bresp, s_axi_rresp, e;
   logic [15:0] mem_wr_addr = 16'h0;
   logic [7:0]  mem_wr_data = 8'h00, status;
   sep_pkg::sep_power_t power_state;
   int err_total = 0, checked = 0;
   sep_spi_if spi ();
   sep_host   i_sep_host (.*);
   sep_device i_sep_device (.*);
   sep_chk    i_sep_chk (.aclk(aclk), .aresetn(aresetn), .cs_n(spi.cs_n), .sck(spi.sck), .serial_in(spi.serial_in),
                         .serial_out(spi.serial_out), .serial_out_oe(spi.serial_out_oe));
   // 250 MHz system clock
   always #2 aclk = ~aclk;
   task automatic report_and_stop;
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   // one write; each channel released when taken, a hung answer ends the run
   task automatic axw(input logic [3:0] a, input logic [31:0] v);
      int n;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 50) begin err_total++; report_and_stop(); end
   endtask : axw
   task automatic axr(input logic [3:0] a, output logic [31:0] r, output logic [1:0] rr);
      int n;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      r = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 50) begin err_total++; report_and_stop(); end
   endtask : axr
   // one frame, then poll until the host is no longer busy
   task automatic run(input logic [7:0] op, input logic [7:0] val, input logic [7:0] len);
      int n;
      axw(sep_pkg::REG_CMD, {8'h00, len, val, op});
      for (n = 0; n < 300; n++) begin
         axr(sep_pkg::REG_STAT, d, e);
         if (d[0] === 1'b0) break;
      end
      if (n == 300) begin err_total++; report_and_stop(); end
   endtask : run
   task automatic sr(input logic [7:0] x);
      run(sep_pkg::OP_STATUS_READ, 8'h00, 8'h02);
      axr(sep_pkg::REG_STAT, d, e);
      `CHK(d[15:8], x)
   endtask : sr
   task automatic wp(input logic lvl, input logic [15:0] a);
      axw(sep_pkg::REG_ADDR, {15'h0000, lvl, a});
   endtask : wp
   // the status value rides in the address-high byte, second in the frame
   task automatic sw(input logic lvl, input logic [7:0] v);
      wp(lvl, {v, 8'h00});
      run(sep_pkg::OP_STATUS_WRITE, v, 8'h02);
   endtask : sw
   task automatic poke(input logic [15:0] a, input logic [7:0] v);
      @(posedge aclk);
      mem_wr_en   <= 1'b1;
      mem_wr_addr <= a;
      mem_wr_data <= v;
      @(posedge aclk);
      mem_wr_en   <= 1'b0;
   endtask : poke
   // main sequence
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      axr(4'hC, d, e);
      `CHK(e, sep_pkg::RESP_SLVERR)
      sr(8'h00);
      run(sep_pkg::OP_SET_LATCH, 8'h00, 8'h01);
      sr(8'h02);
      wp(1'b0, 16'h0000);
      run(sep_pkg::OP_CLEAR_LATCH, 8'h00, 8'h01);
      sr(8'h00);
      run(sep_pkg::OP_SET_LATCH, 8'h00, 8'h01);
      sw(1'b0, 8'hDC);
      sr(8'hCE);
      // whole array protected now, so a backdoor write is turned away
      mem_wr_en <= 1'b1;
      @(posedge aclk);
      `CHK(mem_wr_refused, 1'b1)
      mem_wr_en <= 1'b0;
      `CHK(power_state, sep_pkg::PS_AUTO)
      sw(1'b0, 8'h00);
      sr(8'hCE);
      sw(1'b1, 8'h20);
      sr(8'h22);
      `CHK(status, 8'h22)
      `CHK(power_state, sep_pkg::PS_LOW_IDLE)
      sw(1'b1, 8'h00);
      `CHK(power_state, sep_pkg::PS_STANDBY)
      poke(16'hFFFF, 8'h5A);
      poke(16'h0000, 8'hA5);
      wp(1'b1, 16'hFFFF);
      run(sep_pkg::OP_READ, 8'h00, 8'h05);
      axr(sep_pkg::REG_STAT, d, e);
      `CHK(d[23:8], 16'h05A5)
      run(sep_pkg::OP_FAST_READ, 8'h00, 8'h05);
      axr(sep_pkg::REG_STAT, d, e);
      `CHK(d[15:8], 8'h5A)
      run(sep_pkg::OP_SLEEP, 8'h00, 8'h01);
      `CHK(power_state, sep_pkg::PS_SLEEP)
      run(sep_pkg::OP_SET_LATCH, 8'h00, 8'h01);
      run(sep_pkg::OP_WAKE, 8'h00, 8'h01);
      sr(8'h00);
      // busy array: only status read gets through, device stays active
      array_busy <= 1'b1;
      run(sep_pkg::OP_SET_LATCH, 8'h00, 8'h01);
      sr(8'h01);
      `CHK(power_state, sep_pkg::PS_ACTIVE)
      array_busy <= 1'b0;
      run(sep_pkg::OP_DEEP_SLEEP, 8'h00, 8'h01);
      run(sep_pkg::OP_WAKE, 8'h00, 8'h01);
      `CHK(power_state, sep_pkg::PS_DEEP)
      deep_exit <= 1'b1;
      @(posedge aclk);
      deep_exit <= 1'b0;
      repeat (4) @(posedge aclk);
      `CHK(power_state, sep_pkg::PS_STANDBY)
      report_and_stop();
   end
endmodule : tb
